// >>> rtl/als_pkg.sv
package als_pkg;

  // word and bus geometry
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned CODE_W   = 4;
  localparam int unsigned PROF_W   = 6;
  localparam int unsigned VER_W    = 16;
  localparam int unsigned ADR_W    = 8;
  localparam int unsigned DAT_W    = 32;
  localparam int unsigned SEL_W    = 4;

  // register byte addresses
  localparam logic [ADR_W-1:0] ADR_LINK_STATE = 8'h00;
  localparam logic [ADR_W-1:0] ADR_PROFILE    = 8'h04;
  localparam logic [ADR_W-1:0] ADR_PARAM_BITS = 8'h08;
  localparam logic [ADR_W-1:0] ADR_VERSION    = 8'h0c;
  localparam logic [ADR_W-1:0] ADR_IRQ_STATUS = 8'h10;
  localparam logic [ADR_W-1:0] ADR_IRQ_MASK   = 8'h14;

  // link state word fields
  localparam int unsigned LINK_S2_LSB  = 0;
  localparam int unsigned LINK_S2_CYC  = 7;
  localparam int unsigned LINK_S1_LSB  = 8;
  localparam int unsigned LINK_UPD     = 14;
  localparam int unsigned LINK_S1_CYC  = 15;

  // parameter bits word fields
  localparam int unsigned PAR_S2_LSB   = 0;
  localparam int unsigned PAR_S1_LSB   = 8;

  // slave state codes
  localparam logic [CODE_W-1:0] ST_NO_SUPPLY_MAX  = 4'h3;
  localparam logic [CODE_W-1:0] ST_RESET          = 4'h4;
  localparam logic [CODE_W-1:0] ST_ZERO_NODE      = 4'h6;
  localparam logic [CODE_W-1:0] NO_EXCHANGE_STATE = 4'h7;
  localparam logic [CODE_W-1:0] EXCHANGING_STATE  = 4'h8;
  localparam logic [CODE_W-1:0] ST_RECONFIG       = 4'h9;

  // active slave profiles
  localparam logic [PROF_W-1:0] IO_PLUS_TRANSPARENT_DOUBLE_PROFILE = 6'h01;
  localparam logic [PROF_W-1:0] IO_DOUBLE_PROFILE                  = 6'h02;
  localparam logic [PROF_W-1:0] SINGLE_STANDARD_SLAVE_PROFILE      = 6'h10;
  localparam logic [PROF_W-1:0] SINGLE_EXTENDED_SLAVE_PROFILE      = 6'h20;

  // least interface firmware version, in tenths (1.3)
  localparam logic [VER_W-1:0] MIN_VERSION = 16'h000d;

  // interrupt status bits
  localparam int unsigned IRQ_W         = 5;
  localparam int unsigned IRQ_S1_CHG    = 0;
  localparam int unsigned IRQ_S2_CHG    = 1;
  localparam int unsigned IRQ_EXCH_LOST = 2;
  localparam int unsigned IRQ_UPD_START = 3;
  localparam int unsigned IRQ_CFG_CHG   = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

  // width of the synchronised pin vector
  localparam int unsigned SYNC_W = 2*CODE_W + 3 + PROF_W + 2*CODE_W + VER_W;

  // bus answer machine
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } als_bus_t;

endpackage : als_pkg

// >>> rtl/als_pin_if.sv
`timescale 1ns/1ps
interface als_pin_if import als_pkg::*; ();
  logic [CODE_W-1:0] s1_state;
  logic [CODE_W-1:0] s2_state;
  logic              s1_cyclic;
  logic              s2_cyclic;
  logic              fw_update;
  logic [PROF_W-1:0] profile;
  logic [CODE_W-1:0] s1_param;
  logic [CODE_W-1:0] s2_param;
  logic [VER_W-1:0]  version;

  modport src (output s1_state, s2_state, s1_cyclic, s2_cyclic, fw_update, profile, s1_param, s2_param, version);
  modport dst (input  s1_state, s2_state, s1_cyclic, s2_cyclic, fw_update, profile, s1_param, s2_param, version);
endinterface : als_pin_if

// >>> rtl/als_sync.sv
`timescale 1ns/1ps
module als_sync import als_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic [SYNC_W-1:0] raw_i,
  als_pin_if.src                 pins
);

  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;

  // two flip-flops per pin bit, the first read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else if (ce_i) begin
          meta_q[gi] <= raw_i[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // unpack the settled vector into named fields
  assign {pins.s1_state, pins.s2_state, pins.s1_cyclic, pins.s2_cyclic, pins.fw_update,
          pins.profile, pins.s1_param, pins.s2_param, pins.version} = sync_q;

endmodule : als_sync

// >>> rtl/als_top.sv
`timescale 1ns/1ps
// Function
// RULE1: the link state word is a 16-bit read-only value from 0 to 65535 showing readiness, error and traffic.
// RULE2: the status words carry content only when interface firmware is version 1.3 or later, else zero.
// RULE3: the first slave's four-bit state code sits in bits 8 to 11, with bits 12 and 13 reserved.
// RULE4: the second slave's four-bit state code sits in bits 0 to 3, with bits 4 to 6 reserved.
// RULE5: bit 15 shows cyclic traffic with the first slave and bit 7 cyclic traffic with the second.
// RULE6: state codes mean 0-3 no supply, 4 reset, 6 node zero, 7 no exchange, 8 exchange, 9 reconfiguration.
// RULE7: bits 14 and 15 both read one while an interface firmware update runs.
// RULE8: the profile word shows the active profile in bits 0 to 5 (codes 1, 2, 16, 32), bits 6 to 15 zero.
// RULE9: master-written parameter bits show in bits 0-3 (second slave) and 8-11 (first), read per profile.
// RULE10: reserved bits read zero and software writes to the status words are ignored.
module als_top import als_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [SEL_W-1:0]  wb_sel_i,
  input  wire logic [DAT_W-1:0]  wb_dat_i,
  output logic      [DAT_W-1:0]  wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   irq_o,
  input  wire logic [CODE_W-1:0] s1_state_i,
  input  wire logic [CODE_W-1:0] s2_state_i,
  input  wire logic              s1_cyclic_i,
  input  wire logic              s2_cyclic_i,
  input  wire logic              fw_update_i,
  input  wire logic [PROF_W-1:0] profile_i,
  input  wire logic [CODE_W-1:0] s1_param_i,
  input  wire logic [CODE_W-1:0] s2_param_i,
  input  wire logic [VER_W-1:0]  version_i
);

  als_pin_if pins ();

  // pin inputs cross into the clock domain
  als_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .raw_i ({s1_state_i, s2_state_i, s1_cyclic_i, s2_cyclic_i, fw_update_i,
             profile_i, s1_param_i, s2_param_i, version_i}),
    .pins  (pins)
  );

  logic [WORD_W-1:0] link_q;
  logic [WORD_W-1:0] link_d;
  logic [WORD_W-1:0] prof_q;
  logic [WORD_W-1:0] prof_d;
  logic [WORD_W-1:0] par_q;
  logic [WORD_W-1:0] par_d;
  logic [VER_W-1:0]  ver_q;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_mask_d;
  logic [IRQ_W-1:0]  irq_event;
  logic [DAT_W-1:0]  dat_q;
  logic              ack_q;
  logic              irq_q;
  als_bus_t          bus_q;
  als_bus_t          bus_d;

  // content gate on firmware version and profile
  wire ver_ok    = pins.version >= MIN_VERSION;                         // [RULE2]
  wire single_pr = (pins.profile == SINGLE_STANDARD_SLAVE_PROFILE) ||
                   (pins.profile == SINGLE_EXTENDED_SLAVE_PROFILE);
  wire [CODE_W-1:0] s2_state_v = single_pr ? 4'h0 : pins.s2_state;    // [RULE9]
  wire [CODE_W-1:0] s2_param_v = single_pr ? 4'h0 : pins.s2_param;    // [RULE9]
  wire              s2_cyc_v   = single_pr ? 1'b0 : pins.s2_cyclic;

  // link state word assembly
  always_comb begin
    link_d = '0;                                                        // [RULE10]
    if (ver_ok) begin
      link_d[LINK_S1_LSB +: CODE_W] = pins.s1_state;                    // [RULE3]
      link_d[LINK_S2_LSB +: CODE_W] = s2_state_v;                       // [RULE4]
      link_d[LINK_S1_CYC]           = pins.s1_cyclic | pins.fw_update;  // [RULE5]
      link_d[LINK_S2_CYC]           = s2_cyc_v;                         // [RULE5]
      link_d[LINK_UPD]              = pins.fw_update;                   // [RULE7]
    end
  end

  // profile and parameter bits words
  always_comb begin
    prof_d = '0;
    par_d  = '0;
    if (ver_ok) begin
      prof_d[PROF_W-1:0]           = pins.profile;                      // [RULE8]
      par_d[PAR_S1_LSB +: CODE_W]  = pins.s1_param;                     // [RULE9]
      par_d[PAR_S2_LSB +: CODE_W]  = s2_param_v;                        // [RULE9]
    end
  end

  // status words follow the settled pins every enabled cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_q <= '0;
      prof_q <= '0;
      par_q  <= '0;
      ver_q  <= '0;
    end else if (ce_i) begin
      link_q <= link_d;                                                 // [RULE1]
      prof_q <= prof_d;
      par_q  <= par_d;
      ver_q  <= pins.version;
    end
  end

  // events taken from the change between word and next value
  wire [CODE_W-1:0] s1_old = link_q[LINK_S1_LSB +: CODE_W];
  wire [CODE_W-1:0] s2_old = link_q[LINK_S2_LSB +: CODE_W];
  wire [CODE_W-1:0] s1_new = link_d[LINK_S1_LSB +: CODE_W];
  wire [CODE_W-1:0] s2_new = link_d[LINK_S2_LSB +: CODE_W];
  wire s1_lost = (s1_old == EXCHANGING_STATE) && (s1_new != EXCHANGING_STATE);  // [RULE6]
  wire s2_lost = (s2_old == EXCHANGING_STATE) && (s2_new != EXCHANGING_STATE);  // [RULE6]

  assign irq_event[IRQ_S1_CHG]    = s1_new != s1_old;
  assign irq_event[IRQ_S2_CHG]    = s2_new != s2_old;
  assign irq_event[IRQ_EXCH_LOST] = s1_lost | s2_lost;
  assign irq_event[IRQ_UPD_START] = link_d[LINK_UPD] & ~link_q[LINK_UPD];
  assign irq_event[IRQ_CFG_CHG]   = (prof_d != prof_q) || (par_d != par_q);

  // bus decode; writes commit at the edge that completes the answer
  wire bus_req   = wb_cyc_i & wb_stb_i;
  wire wr_commit = bus_req & wb_we_i & (bus_q == BUS_ACK) & wb_sel_i[0];
  wire hit_stat  = wb_adr_i == ADR_IRQ_STATUS;
  wire hit_mask  = wb_adr_i == ADR_IRQ_MASK;
  wire [IRQ_W-1:0] clr_bits = (wr_commit && hit_stat) ? wb_dat_i[IRQ_W-1:0] : '0;

  // sticky status: a new event beats a clear in the same cycle
  assign irq_stat_d = (irq_stat_q & ~clr_bits) | irq_event;
  assign irq_mask_d = (wr_commit && hit_mask) ? wb_dat_i[IRQ_W-1:0] : irq_mask_q;

  // read selection; status words ignore writes, unmapped reads zero
  wire [DAT_W-1:0] rd_data =
    (wb_adr_i == ADR_LINK_STATE) ? {16'h0000, link_q} :                  // [RULE10]
    (wb_adr_i == ADR_PROFILE)    ? {16'h0000, prof_q} :
    (wb_adr_i == ADR_PARAM_BITS) ? {16'h0000, par_q}  :
    (wb_adr_i == ADR_VERSION)    ? {16'h0000, ver_q}  :
    hit_stat                     ? {27'h0000000, irq_stat_q} :
    hit_mask                     ? {27'h0000000, irq_mask_q} :
                                   32'h00000000;

  // interrupt registers and level output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
      irq_q      <= 1'b0;
    end else if (ce_i) begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // answer machine: one ack per request, dropped the cycle after
  always_comb begin
    case (bus_q)
      BUS_IDLE: bus_d = bus_req ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  bus_d = BUS_IDLE;
      default:  bus_d = BUS_IDLE;
    endcase
  end

  // bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
      ack_q <= 1'b0;
      dat_q <= '0;
    end else if (ce_i) begin
      bus_q <= bus_d;
      ack_q <= (bus_q == BUS_IDLE) & bus_req;
      if ((bus_q == BUS_IDLE) && bus_req) begin
        dat_q <= wb_we_i ? 32'h00000000 : rd_data;
      end
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign irq_o    = irq_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd_req;
    ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && bus_q == BUS_IDLE;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 ($past(ce_i) ? !wb_ack_o : wb_ack_o);
  endsequence

  a_bus_ack_pulse: assert property (s_rd_req |=> s_ack_pulse)
    else $error("ack not a single pulse after a read");

  a_link_upper_zero: assert property ( // [RULE1]
    (s_rd_req and (wb_adr_i == ADR_LINK_STATE)) |=> wb_dat_o[DAT_W-1:WORD_W] == 16'h0000
      && wb_dat_o[WORD_W-1:0] == $past(link_q))
    else $error("link word read wrong");

  a_old_fw_blank: assert property ( // [RULE2]
    ce_i && pins.version < MIN_VERSION |=> link_q == 16'h0000 && prof_q == 16'h0000 && par_q == 16'h0000)
    else $error("content shown with old firmware");

  a_s1_code_place: assert property ( // [RULE3]
    ce_i && ver_ok |=> link_q[LINK_S1_LSB +: CODE_W] == $past(pins.s1_state) && link_q[13:12] == 2'h0)
    else $error("first slave code misplaced");

  a_s2_code_place: assert property ( // [RULE4]
    ce_i && ver_ok && !single_pr |=> link_q[LINK_S2_LSB +: CODE_W] == $past(pins.s2_state))
    else $error("second slave code misplaced");

  a_cyclic_flags: assert property ( // [RULE5]
    ce_i && ver_ok && !pins.fw_update && !single_pr |=> link_q[LINK_S1_CYC] == $past(pins.s1_cyclic)
      && link_q[LINK_S2_CYC] == $past(pins.s2_cyclic))
    else $error("cyclic flag wrong");

  a_exch_lost_irq: assert property ( // [RULE6]
    ce_i && link_q[LINK_S1_LSB +: CODE_W] == EXCHANGING_STATE && s1_new != EXCHANGING_STATE
      |=> irq_stat_q[IRQ_EXCH_LOST])
    else $error("exchange loss not flagged");

  a_update_marks: assert property ( // [RULE7]
    ce_i && ver_ok && pins.fw_update |=> link_q[LINK_UPD] && link_q[LINK_S1_CYC])
    else $error("update marks missing");

  a_profile_field: assert property ( // [RULE8]
    ce_i && ver_ok |=> prof_q[PROF_W-1:0] == $past(pins.profile) && prof_q[WORD_W-1:PROF_W] == 10'h000)
    else $error("profile word wrong");

  a_param_field: assert property ( // [RULE9]
    ce_i && ver_ok |=> par_q[PAR_S1_LSB +: CODE_W] == $past(pins.s1_param) && par_q[7:4] == 4'h0
      && par_q[15:12] == 4'h0)
    else $error("parameter bits wrong");

  a_reserved_zero: assert property ( // [RULE10]
    link_q[6:4] == 3'h0 && link_q[13:12] == 2'h0 && (link_q[LINK_UPD] == 1'b0 || link_q[LINK_S1_CYC] == 1'b1))
    else $error("reserved link bits set");

  a_status_ro: assert property ( // [RULE10]
    ce_i && bus_q == BUS_ACK && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ADR_LINK_STATE
      |=> link_q == $past(link_d))
    else $error("status word took a write");

  a_set_beats_clear: assert property (
    ce_i && irq_event[IRQ_S1_CHG] |=> irq_stat_q[IRQ_S1_CHG])
    else $error("event lost");

  a_irq_level: assert property (
    ce_i && |(irq_stat_q & irq_mask_q) |=> irq_o)
    else $error("irq not raised");

  // read-back path: the word sampled at the taking edge is what the master sees
  a_prof_read: assert property ( // [RULE8]
    (s_rd_req and (wb_adr_i == ADR_PROFILE)) |=> wb_dat_o == {16'h0000, $past(prof_q)})
    else $error("profile read wrong");

  a_param_read: assert property ( // [RULE9]
    (s_rd_req and (wb_adr_i == ADR_PARAM_BITS)) |=> wb_dat_o == {16'h0000, $past(par_q)})
    else $error("parameter read wrong");

  a_version_read: assert property ( // [RULE2]
    (s_rd_req and (wb_adr_i == ADR_VERSION)) |=> wb_dat_o == {16'h0000, $past(ver_q)})
    else $error("version read wrong");

  a_status_read: assert property (
    (s_rd_req and (wb_adr_i == ADR_IRQ_STATUS)) |=> wb_dat_o == {27'h0000000, $past(irq_stat_q)})
    else $error("status read wrong");

  a_unmapped_zero: assert property ( // [RULE10]
    (s_rd_req and (wb_adr_i > ADR_IRQ_MASK)) |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  a_write_zero_data: assert property ( // [RULE10]
    ce_i && bus_req && wb_we_i && bus_q == BUS_IDLE |=> wb_dat_o == 32'h00000000)
    else $error("write returned data");

  a_no_ack_idle: assert property (
    ce_i && !bus_req && bus_q == BUS_IDLE |=> !wb_ack_o)
    else $error("ack without request");

  a_read_data_held: assert property (
    ce_i && !(bus_req && bus_q == BUS_IDLE) |=> $stable(wb_dat_o))
    else $error("read data moved between answers");

  // second slave fields and events, then update-start and configuration-change events
  a_s2_param_place: assert property ( // [RULE9]
    ce_i && ver_ok && !single_pr |=> par_q[PAR_S2_LSB +: CODE_W] == $past(pins.s2_param))
    else $error("second slave parameter bits misplaced");

  a_single_hides_s2: assert property ( // [RULE9]
    ce_i && ver_ok && single_pr |=> link_q[LINK_S2_CYC:LINK_S2_LSB] == 8'h00 && par_q[PAR_S2_LSB +: CODE_W] == 4'h0)
    else $error("second slave shown in single profile");

  a_s2_chg_irq: assert property ( // [RULE4]
    ce_i && s2_new != s2_old |=> irq_stat_q[IRQ_S2_CHG])
    else $error("second slave change not flagged");

  a_exch_lost_s2: assert property ( // [RULE6]
    ce_i && s2_old == EXCHANGING_STATE && s2_new != EXCHANGING_STATE |=> irq_stat_q[IRQ_EXCH_LOST])
    else $error("second slave exchange loss not flagged");

  a_upd_start_irq: assert property ( // [RULE7]
    ce_i && ver_ok && pins.fw_update && !link_q[LINK_UPD] |=> irq_stat_q[IRQ_UPD_START])
    else $error("update start not flagged");

  a_cfg_chg_irq: assert property ( // [RULE8]
    ce_i && (prof_d != prof_q || par_d != par_q) |=> irq_stat_q[IRQ_CFG_CHG])
    else $error("configuration change not flagged");

  // interrupt registers
  a_clear_works: assert property (
    ce_i && wr_commit && hit_stat && wb_dat_i[IRQ_S1_CHG] && !irq_event[IRQ_S1_CHG] |=> !irq_stat_q[IRQ_S1_CHG])
    else $error("status bit not cleared");

  a_mask_write: assert property (
    ce_i && wr_commit && hit_mask |=> irq_mask_q == $past(wb_dat_i[IRQ_W-1:0]))
    else $error("mask write lost");

  a_irq_quiet: assert property (
    ce_i && !(|(irq_stat_q & irq_mask_q)) |=> !irq_o)
    else $error("irq raised with nothing pending");

  // clock enable low freezes every register
  a_freeze_words: assert property (
    !ce_i |=> $stable(link_q) && $stable(prof_q) && $stable(par_q))
    else $error("words moved while frozen");

  a_freeze_bus: assert property (
    !ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o))
    else $error("bus moved while frozen");

  a_freeze_irq: assert property (
    !ce_i |=> $stable(irq_o) && $stable(irq_stat_q) && $stable(irq_mask_q))
    else $error("interrupt state moved while frozen");

endmodule : als_top

// >>> verif/als_master_model.sv
`timescale 1ns/1ps
module als_master_model import als_pkg::*; (
  output logic [CODE_W-1:0] s1_state_o,
  output logic [CODE_W-1:0] s2_state_o,
  output logic              s1_cyclic_o,
  output logic              s2_cyclic_o,
  output logic              fw_update_o,
  output logic [PROF_W-1:0] profile_o,
  output logic [CODE_W-1:0] s1_param_o,
  output logic [CODE_W-1:0] s2_param_o,
  output logic [VER_W-1:0]  version_o
);
  // pins start quiet, with no interface firmware reported
  initial begin
    s1_state_o  = 4'h0;
    s2_state_o  = 4'h0;
    s1_cyclic_o = 1'b0;
    s2_cyclic_o = 1'b0;
    fw_update_o = 1'b0;
    profile_o   = 6'h00;
    s1_param_o  = 4'h0;
    s2_param_o  = 4'h0;
    version_o   = 16'h0000;
  end

  // one call per master cycle, made just after a rising edge; levels then stay static
  task automatic drive(input logic [CODE_W-1:0] st1, input logic [CODE_W-1:0] st2, input logic cy1,
                       input logic cy2, input logic upd, input logic [PROF_W-1:0] prof,
                       input logic [CODE_W-1:0] p1, input logic [CODE_W-1:0] p2, input logic [VER_W-1:0] ver);
    s1_state_o  <= st1;
    s2_state_o  <= st2;
    s1_cyclic_o <= cy1;
    s2_cyclic_o <= cy2;
    fw_update_o <= upd;
    profile_o   <= prof;
    s1_param_o  <= p1;
    s2_param_o  <= p2;
    version_o   <= ver;
  endtask : drive
endmodule : als_master_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench import als_pkg::*;;
  logic              clk_i;
  logic              rst_i;
  logic              ce_i;
  logic              wb_cyc;
  logic              wb_stb;
  logic              wb_we;
  logic [ADR_W-1:0]  wb_adr;
  logic [SEL_W-1:0]  wb_sel;
  logic [DAT_W-1:0]  wb_dat_w;
  logic [DAT_W-1:0]  wb_dat_r;
  logic              wb_ack;
  logic              irq;
  logic [CODE_W-1:0] st1, st2, p1, p2;
  logic              cy1, cy2, upd;
  logic [PROF_W-1:0] prof;
  logic [VER_W-1:0]  ver;
  logic [DAT_W-1:0]  q;
  int                fails;
  int                checks;
  logic [CODE_W-1:0] codes [7] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
  logic [PROF_W-1:0] profs [4] = '{6'h01, 6'h02, 6'h10, 6'h20};

  // partner and device under test
  als_master_model mdl (.s1_state_o(st1), .s2_state_o(st2), .s1_cyclic_o(cy1), .s2_cyclic_o(cy2),
    .fw_update_o(upd), .profile_o(prof), .s1_param_o(p1), .s2_param_o(p2), .version_o(ver));
  als_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .irq_o(irq), .s1_state_i(st1), .s2_state_i(st2), .s1_cyclic_i(cy1),
    .s2_cyclic_i(cy2), .fw_update_i(upd), .profile_i(prof), .s1_param_i(p1), .s2_param_i(p2),
    .version_i(ver));

  // clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic close_out;
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] dat);
    int n;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_dat_w <= dat;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    if (n == 20) begin
      fails++;
      close_out();
    end
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input string name, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] exp);
    wb(1'b0, adr, 32'h0);
    check(name, q, exp);
  endtask : rd

  // pins need three edges to reach the words; allow five
  task automatic settle;
    repeat (5) @(posedge clk_i);
  endtask : settle

  task automatic chk_irq(input logic exp);
    @(negedge clk_i);
    check("irq", {31'h0, irq}, {31'h0, exp});
    @(posedge clk_i);
  endtask : chk_irq

  // expected link word from slave fields; single profiles hide the second slave
  function automatic logic [DAT_W-1:0] link_exp(input logic [3:0] a, input logic [3:0] b, input logic ca,
                                                input logic cb, input logic up, input logic dbl);
    logic [15:0] w;
    w = {ca, 3'h0, a, cb, 3'h0, b};
    if (!dbl) w[7:0] = 8'h00;
    if (up) w[15:14] = 2'b11;
    return {16'h0000, w};
  endfunction : link_exp

  // main sequence
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 24; a += 4) rd("reset", a[7:0], 32'h0);
    mdl.drive(4'h8, 4'h7, 1'b1, 1'b1, 1'b0, 6'h02, 4'h5, 4'ha, 16'h000c);
    settle();
    rd("old_link", ADR_LINK_STATE, 32'h0);
    rd("old_param", ADR_PARAM_BITS, 32'h0);
    for (int i = 0; i < 7; i++) begin
      mdl.drive(codes[i], codes[6-i], i[0], !i[0], 1'b0, 6'h02, 4'h3, 4'hc, 16'h000d);
      settle();
      rd("link", ADR_LINK_STATE, link_exp(codes[i], codes[6-i], i[0], !i[0], 1'b0, 1'b1));
    end
    for (int j = 0; j < 4; j++) begin
      mdl.drive(4'h8, 4'h8, 1'b1, 1'b1, 1'b0, profs[j], 4'h9, 4'h6, 16'h0013);
      settle();
      rd("profile", ADR_PROFILE, {26'h0, profs[j]});
      rd("param", ADR_PARAM_BITS, (profs[j] < 6'h10) ? 32'h0906 : 32'h0900);
      rd("link_prof", ADR_LINK_STATE, link_exp(4'h8, 4'h8, 1'b1, 1'b1, 1'b0, profs[j] < 6'h10));
    end
    mdl.drive(4'h9, 4'h4, 1'b0, 1'b1, 1'b1, 6'h02, 4'h1, 4'h2, 16'h000d);
    settle();
    rd("update", ADR_LINK_STATE, link_exp(4'h9, 4'h4, 1'b0, 1'b1, 1'b1, 1'b1));
    for (int a = 0; a < 12; a += 4) wb(1'b1, a[7:0], 32'hffff_ffff);
    rd("wr_link", ADR_LINK_STATE, link_exp(4'h9, 4'h4, 1'b0, 1'b1, 1'b1, 1'b1));
    rd("wr_prof", ADR_PROFILE, 32'h0002);
    rd("wr_param", ADR_PARAM_BITS, 32'h0102);
    rd("unmapped", 8'h20, 32'h0);
    // interrupt: enable the first-slave change event, clear, raise, clear, then mask
    wb(1'b1, ADR_IRQ_MASK, 32'h1 << IRQ_S1_CHG);
    rd("mask", ADR_IRQ_MASK, 32'h1 << IRQ_S1_CHG);
    wb(1'b1, ADR_IRQ_STATUS, 32'h1f);
    chk_irq(1'b0);
    mdl.drive(4'h7, 4'h4, 1'b0, 1'b1, 1'b0, 6'h02, 4'h1, 4'h2, 16'h000d);
    settle();
    chk_irq(1'b1);
    wb(1'b0, ADR_IRQ_STATUS, 32'h0);
    check("s1_chg", (q >> IRQ_S1_CHG) & 32'h1, 32'h1);
    wb(1'b1, ADR_IRQ_STATUS, 32'h1 << IRQ_S1_CHG);
    chk_irq(1'b0);
    wb(1'b1, ADR_IRQ_MASK, 32'h0);
    mdl.drive(4'h8, 4'h4, 1'b1, 1'b1, 1'b0, 6'h02, 4'h1, 4'h2, 16'h000d);
    settle();
    chk_irq(1'b0);
    wb(1'b0, ADR_IRQ_STATUS, 32'h0);
    check("masked_chg", (q >> IRQ_S1_CHG) & 32'h1, 32'h1);
    rd("version", ADR_VERSION, 32'h000d);
    // freeze: pins move while the enable is low, the words keep their old value
    ce_i <= 1'b0;
    mdl.drive(4'h4, 4'h4, 1'b1, 1'b1, 1'b0, 6'h02, 4'h1, 4'h2, 16'h000d);
    settle();
    ce_i <= 1'b1;
    rd("frozen", ADR_LINK_STATE, link_exp(4'h8, 4'h4, 1'b1, 1'b1, 1'b0, 1'b1));
    settle();
    rd("thawed", ADR_LINK_STATE, link_exp(4'h4, 4'h4, 1'b1, 1'b1, 1'b0, 1'b1));
    close_out();
  end
endmodule : testbench
